//--- design/acrs_defs.svh
`ifndef ACRS_DEFS_SVH
`define ACRS_DEFS_SVH
`define ACRS_OFF_SEL      32'h0000_0000
`define ACRS_OFF_CTRL     32'h0000_0004
`define ACRS_OFF_ACTIVE   32'h0000_0008
`define ACRS_OFF_STATUS   32'h0000_000c
`define ACRS_OFF_MASK     32'h0000_0010
`define ACRS_OFF_DECODE   32'h0000_0014
`define ACRS_CH_LSB       0
`define ACRS_CH_MSB       5
`define ACRS_REF_LSB      8
`define ACRS_REF_MSB      10
`define ACRS_CTRL_START   0
`define ACRS_CTRL_AUTO    1
`define ACRS_CTRL_EN      2
`define ACRS_ST_DONE      0
`define ACRS_ST_START     1
`define ACRS_SE_LAST      6'h0a
`define ACRS_DIFF_FIRST   6'h0b
`define ACRS_DIFF_LAST    6'h1d
`define ACRS_CODE_BANDGAP 6'h1e
`define ACRS_CODE_GROUND  6'h1f
`define ACRS_CONV_CYCLES  8'd13
`define ACRS_CONV_TAIL    8'd3
`endif

//--- design/acrs_pkg.sv
package acrs_pkg;
    typedef enum logic [2:0] {
        ACRS_IDLE = 3'b001,
        ACRS_CONV = 3'b010,
        ACRS_LAST = 3'b100
    } acrs_state_t;
    typedef enum logic [2:0] {
        ACRS_SRC_NONE   = 3'h0,
        ACRS_SRC_SINGLE = 3'h1,
        ACRS_SRC_DIFF   = 3'h2,
        ACRS_SRC_BANDGP = 3'h3,
        ACRS_SRC_GROUND = 3'h4
    } acrs_src_t;
endpackage

//--- design/acrs_decode.sv
`timescale 1ns/1ps
`include "acrs_defs.svh"
module acrs_decode
    import acrs_pkg::*;
(
    input  wire logic [5:0] code,
    output acrs_src_t       source,
    output logic      [3:0] pos_input,
    output logic      [3:0] neg_input,
    output logic            gain_high,
    output logic            offset_path
);
    always_comb begin
        source      = ACRS_SRC_NONE;
        pos_input   = 4'h0;
        neg_input   = 4'h0;
        gain_high   = 1'b0;
        if (code <= `ACRS_SE_LAST) begin
            source    = ACRS_SRC_SINGLE; // R9
            pos_input = code[3:0];
        end else if (code <= `ACRS_DIFF_LAST) begin
            source = ACRS_SRC_DIFF; // R10
            case (code)
                6'h0b: begin pos_input = 4'h0; neg_input = 4'h1; gain_high = 1'b1; end
                6'h0c: begin pos_input = 4'h0; neg_input = 4'h1; end
                6'h0d: begin pos_input = 4'h1; neg_input = 4'h1; gain_high = 1'b1; end
                6'h0e: begin pos_input = 4'h2; neg_input = 4'h1; gain_high = 1'b1; end
                6'h0f: begin pos_input = 4'h2; neg_input = 4'h1; end
                6'h10: begin pos_input = 4'h2; neg_input = 4'h3; end
                6'h11: begin pos_input = 4'h3; neg_input = 4'h3; gain_high = 1'b1; end
                6'h12: begin pos_input = 4'h4; neg_input = 4'h3; gain_high = 1'b1; end
                6'h13: begin pos_input = 4'h4; neg_input = 4'h3; end
                6'h14: begin pos_input = 4'h4; neg_input = 4'h5; gain_high = 1'b1; end
                6'h15: begin pos_input = 4'h4; neg_input = 4'h5; end
                6'h16: begin pos_input = 4'h5; neg_input = 4'h5; gain_high = 1'b1; end
                6'h17: begin pos_input = 4'h6; neg_input = 4'h5; gain_high = 1'b1; end
                6'h18: begin pos_input = 4'h6; neg_input = 4'h5; end
                6'h19: begin pos_input = 4'h8; neg_input = 4'h9; gain_high = 1'b1; end
                6'h1a: begin pos_input = 4'h8; neg_input = 4'h9; end
                6'h1b: begin pos_input = 4'h9; neg_input = 4'h9; gain_high = 1'b1; end
                6'h1c: begin pos_input = 4'ha; neg_input = 4'h9; gain_high = 1'b1; end
                default: begin pos_input = 4'ha; neg_input = 4'h9; end
            endcase
        end else if (code == `ACRS_CODE_BANDGAP) begin
            source = ACRS_SRC_BANDGP; // R12
        end else if (code == `ACRS_CODE_GROUND) begin
            source = ACRS_SRC_GROUND; // R12
        end
    end

    // Same pin on both sides at high gain gives an offset reading
    assign offset_path = (source == ACRS_SRC_DIFF) && gain_high && (pos_input == neg_input); // R11
endmodule

//--- design/acrs_top.sv
`timescale 1ns/1ps
`include "acrs_defs.svh"
// Operation
// R1 - Software fields sit in a buffer, copied to active selection at safe points.
// R2 - While idle, active selection tracks the buffer every cycle.
// R3 - Active selection frozen from conversion start.
// R4 - Tracking resumes in the last cycle, when the done flag sets.
// R5 - Conversion starts on the clock edge after the start bit write.
// R6 - Software waits one cycle after start before changing the selection.
// R7 - A trigger may start conversion anytime; it uses the active selection then. The code starts one only from idle; edges mid-conversion are lost.
// R8 - Software times selection updates carefully under auto-triggering.
// R9 - Codes 0 to 10 select single-ended inputs 0 to 10.
// R10 - Codes 11 to 29 select fixed differential pairs at 20x or 1x.
// R11 - Same-input differential pairs at 20x form an offset path.
// R12 - Code 30 selects the 1.1V reference, code 31 ground.
// R13 - Buffer writes during a frozen selection are kept and applied later.
module acrs_top
    import acrs_pkg::*;
#(
    parameter logic [7:0] CONV_CYCLES = `ACRS_CONV_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        trigger_in,
    output logic      [5:0]  active_channel,
    output logic      [2:0]  active_reference,
    output acrs_src_t        active_source,
    output logic      [3:0]  active_pos_input,
    output logic      [3:0]  active_neg_input,
    output logic             active_gain_high,
    output logic             active_offset_path,
    output logic             converting,
    output logic             irq
);
    // ==========================================================
    // Bus slave
    logic        wr_pend;
    logic        rd_pend;
    logic [31:0] addr_q;
    logic [5:0]  channel_select_code;
    logic [2:0]  reference_select_code;
    logic        auto_trigger_enable;
    logic        converter_enable;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        start_req;
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_q;
    acrs_state_t state;
    logic [7:0]  cycle_cnt;
    logic        done_pulse;
    logic        start_pulse;
    logic        wr_sel;
    logic        wr_ctrl;
    logic        wr_status;
    logic        wr_mask;
    acrs_src_t   dec_source;
    logic [3:0]  dec_pos;
    logic [3:0]  dec_neg;
    logic        dec_gain;
    logic        dec_offset;

    wire addr_phase = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 32'h0000_0000;
        end else if (hready) begin
            wr_pend <= addr_phase && hwrite;
            rd_pend <= addr_phase && !hwrite;
            if (addr_phase) begin
                addr_q <= {haddr[31:2], 2'b00};
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_sel    = wr_pend && (addr_q == `ACRS_OFF_SEL);
    assign wr_ctrl   = wr_pend && (addr_q == `ACRS_OFF_CTRL);
    assign wr_status = wr_pend && (addr_q == `ACRS_OFF_STATUS);
    assign wr_mask   = wr_pend && (addr_q == `ACRS_OFF_MASK);

    // Buffer is always writable; copies out only at safe points
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            channel_select_code   <= 6'h00;
            reference_select_code <= 3'h0;
        end else if (wr_sel) begin
            channel_select_code   <= hwdata[`ACRS_CH_MSB:`ACRS_CH_LSB]; // R1
            reference_select_code <= hwdata[`ACRS_REF_MSB:`ACRS_REF_LSB]; // R1
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_trigger_enable <= 1'b0;
            converter_enable    <= 1'b0;
            mask                <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                auto_trigger_enable <= hwdata[`ACRS_CTRL_AUTO];
                converter_enable    <= hwdata[`ACRS_CTRL_EN];
            end
            if (wr_mask) begin
                mask <= hwdata[`ACRS_ST_START:`ACRS_ST_DONE];
            end
        end
    end

    // Start bit stays set until the conversion is taken up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_req <= 1'b0;
        end else if (wr_ctrl && hwdata[`ACRS_CTRL_START] && hwdata[`ACRS_CTRL_EN]) begin
            start_req <= 1'b1;
        end else if (start_pulse) begin
            start_req <= 1'b0;
        end
    end

    // ==========================================================
    // Trigger input, off-domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_q  <= 1'b0;
        end else begin
            trig_s1 <= trigger_in;
            trig_s2 <= trig_s1;
            trig_q  <= trig_s2;
        end
    end

    // ==========================================================
    // Conversion sequencer
    wire trig_edge = trig_s2 && !trig_q && auto_trigger_enable && converter_enable; // R7
    assign start_pulse = (state == ACRS_IDLE) && (start_req || trig_edge); // R5
    assign done_pulse  = (state == ACRS_LAST);
    assign converting  = (state != ACRS_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= ACRS_IDLE;
            cycle_cnt <= 8'h00;
        end else begin
            case (state)
                ACRS_IDLE: begin
                    if (start_pulse) begin
                        state     <= ACRS_CONV;
                        cycle_cnt <= 8'h00;
                    end
                end
                ACRS_CONV: begin
                    cycle_cnt <= cycle_cnt + 8'h01;
                    // Tail covers the start edge and the final reload cycle
                    if (cycle_cnt >= CONV_CYCLES - `ACRS_CONV_TAIL) begin
                        state <= ACRS_LAST;
                    end
                end
                ACRS_LAST: begin
                    state <= ACRS_IDLE;
                end
                default: begin
                    state <= ACRS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Active selection
    // Frozen during conversion so sampling sees a steady input; buffer keeps
    // any newer write and it lands once tracking resumes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_channel   <= 6'h00;
            active_reference <= 3'h0;
        end else if (state != ACRS_CONV) begin // R2 R3 R4 R13
            active_channel   <= channel_select_code; // R2
            active_reference <= reference_select_code;
        end
    end

    acrs_decode u_decode (
        .code        (active_channel),
        .source      (dec_source),
        .pos_input   (dec_pos),
        .neg_input   (dec_neg),
        .gain_high   (dec_gain),
        .offset_path (dec_offset)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_source      <= ACRS_SRC_NONE;
            active_pos_input   <= 4'h0;
            active_neg_input   <= 4'h0;
            active_gain_high   <= 1'b0;
            active_offset_path <= 1'b0;
        end else begin
            active_source      <= dec_source;
            active_pos_input   <= dec_pos;
            active_neg_input   <= dec_neg;
            active_gain_high   <= dec_gain;
            active_offset_path <= dec_offset;
        end
    end

    // ==========================================================
    // Interrupt status: set wins over write-one-to-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= 2'h0;
        end else begin
            status[`ACRS_ST_DONE]  <= done_pulse ||
                (status[`ACRS_ST_DONE] && !(wr_status && hwdata[`ACRS_ST_DONE])); // R4
            status[`ACRS_ST_START] <= start_pulse ||
                (status[`ACRS_ST_START] && !(wr_status && hwdata[`ACRS_ST_START]));
        end
    end

    assign irq = |(status & mask);

    // ==========================================================
    // Read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            case ({haddr[31:2], 2'b00})
                `ACRS_OFF_SEL:    hrdata <= {21'h0, reference_select_code, 2'h0,
                                             channel_select_code};
                `ACRS_OFF_CTRL:   hrdata <= {29'h0, converter_enable, auto_trigger_enable,
                                             start_req};
                `ACRS_OFF_ACTIVE: hrdata <= {21'h0, active_reference, 2'h0, active_channel};
                `ACRS_OFF_STATUS: hrdata <= {29'h0, converting, status};
                `ACRS_OFF_MASK:   hrdata <= {30'h0, mask};
                `ACRS_OFF_DECODE: hrdata <= {16'h0, 3'h0, active_offset_path, active_gain_high,
                                             active_source, active_neg_input, active_pos_input};
                default:          hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

//--- dv/acrs_top_asserts.sv
`timescale 1ns/1ps
module acrs_top_asserts
    import acrs_pkg::*;
#(
    parameter logic [7:0] CONV_CYCLES = 8'd13
) (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [5:0] active_channel,
    input wire logic [2:0] active_reference,
    input wire acrs_src_t  active_source,
    input wire logic [3:0] active_pos_input,
    input wire logic       active_gain_high,
    input wire logic       active_offset_path,
    input wire logic       converting
);
    // ==========
    // Cycles already spent converting
    int unsigned run;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) run <= 0;
        else run <= converting ? run + 1 : 0;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========
    // Decode lags the channel by one cycle, so skip the first edge after reset
    AST_SE: assert property ($past(hresetn) && $past(active_channel) <= 6'h0a |->
        active_source == ACRS_SRC_SINGLE && active_pos_input == $past(active_channel[3:0]))
        else $error("single-ended decode wrong");
    AST_DIFF: assert property ($past(hresetn) &&
        $past(active_channel) inside {[6'h0b:6'h1d]} |-> active_source == ACRS_SRC_DIFF)
        else $error("differential decode wrong");
    AST_OFFSET: assert property ($past(hresetn) |-> active_offset_path ==
        ($past(active_channel) inside {6'h0d, 6'h11, 6'h16, 6'h1b}))
        else $error("offset path wrong");
    AST_BANDGAP: assert property ($past(hresetn) && $past(active_channel) == 6'h1e |->
        active_source == ACRS_SRC_BANDGP && !active_gain_high)
        else $error("bandgap decode wrong");
    AST_GROUND: assert property ($past(hresetn) && $past(active_channel) == 6'h1f |->
        active_source == ACRS_SRC_GROUND && !active_gain_high)
        else $error("ground decode wrong");
    AST_FROZEN: assert property (converting && run >= 1 && run <= CONV_CYCLES - 2 |->
        $stable(active_channel) && $stable(active_reference))
        else $error("selection moved during conversion");
    AST_HOLD: assert property (converting && run < CONV_CYCLES - 2 |=> converting)
        else $error("conversion ended early");
    AST_END: assert property (converting && run == CONV_CYCLES - 2 |=> !converting)
        else $error("conversion ran long");
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus wait or error seen");
    cover property ($rose(converting));
    cover property ($fell(converting));
    cover property (active_offset_path);
    cover property (active_source == ACRS_SRC_GROUND);
endmodule
bind acrs_top acrs_top_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_asserts (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .active_channel(active_channel), .active_reference(active_reference),
    .active_source(active_source), .active_pos_input(active_pos_input),
    .active_gain_high(active_gain_high), .active_offset_path(active_offset_path),
    .converting(converting));

//--- dv/acrs_top_tb_top.sv
`timescale 1ns/1ps
`include "acrs_defs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    $display("[ERR] %s exp %h got %h", n, e, g); miscompares++; end end
module acrs_top_tb_top;
    import acrs_pkg::*;
    localparam logic [7:0]  CONV = 8'd13;
    localparam logic [75:0] POS_T = 76'haa98866544443222100;
    localparam logic [75:0] NEG_T = 76'h9999955555333311111;
    localparam logic [18:0] GAIN_T = 19'b0110101101011001101;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, trigger_in = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, lfsr = 32'h43cb;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0, active_reference, refs;
    logic        hready, hreadyout, hresp, active_gain_high, active_offset_path, converting, irq;
    logic [5:0]  active_channel, code;
    logic [3:0]  active_pos_input, active_neg_input;
    acrs_src_t   active_source;
    logic [12:0] m, seen_dec;
    int          miscompares = 0, checks_done = 0, cycles = 0, run = 0, last_len = 0, k;
    assign hready = hreadyout;
    assign seen_dec = {active_offset_path, active_gain_high, active_source, active_neg_input,
                       active_pos_input};
    acrs_top #(.CONV_CYCLES(CONV)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .trigger_in(trigger_in), .active_channel(active_channel),
        .active_reference(active_reference), .active_source(active_source),
        .active_pos_input(active_pos_input), .active_neg_input(active_neg_input),
        .active_gain_high(active_gain_high), .active_offset_path(active_offset_path),
        .converting(converting), .irq(irq));
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    // ==========
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] sel_word(input logic [5:0] c, input logic [2:0] r);
        return {21'h0, r, 2'b00, c};
    endfunction
    // Expected {offset, gain, source, neg, pos}
    function automatic logic [12:0] exp_dec(input logic [5:0] c);
        int i;
        i = int'(c) - 11;
        if (c <= 6'h0a) return {2'b00, ACRS_SRC_SINGLE, 4'h0, c[3:0]};
        if (c == 6'h1e) return {2'b00, ACRS_SRC_BANDGP, 8'h00};
        if (c == 6'h1f) return {2'b00, ACRS_SRC_GROUND, 8'h00};
        return {(c inside {6'h0d, 6'h11, 6'h16, 6'h1b}), GAIN_T[i], ACRS_SRC_DIFF,
            NEG_T[i*4+:4], POS_T[i*4+:4]};
    endfunction
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_idle();
        for (k = 0; k < 100 && converting !== 1'b0; k++) begin
            @(posedge hclk);
            #1;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Conversion length and hang guard
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (converting === 1'b1) run <= run + 1;
        else if (run != 0) begin
            last_len <= run;
            run <= 0;
        end
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    // ==========
    // Main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int c = 0; c < 32; c++) begin
            lfsr = lfsr_next(lfsr);
            code = c[5:0];
            refs = lfsr[2:0];
            xfer(1'b1, `ACRS_OFF_SEL, sel_word(code, refs));
            repeat (2) @(posedge hclk);
            #1;
            `CHK("active_ch", code, active_channel)
            m = (code <= 6'h0a) ? 13'h1f0f : (code >= 6'h1e) ? 13'h1f00 : 13'h1fff;
            `CHK("decode", exp_dec(code) & m, seen_dec & m)
            xfer(1'b0, `ACRS_OFF_ACTIVE, 32'h0);
            `CHK("active_reg", sel_word(code, refs), rd)
            xfer(1'b0, `ACRS_OFF_DECODE, 32'h0);
            `CHK("decode_reg", {19'h0, exp_dec(code)}, rd)
        end
        xfer(1'b1, `ACRS_OFF_MASK, 32'h1);
        xfer(1'b1, `ACRS_OFF_SEL, sel_word(6'h05, 3'h2));
        xfer(1'b1, `ACRS_OFF_CTRL, 32'h5);
        @(posedge hclk);
        #1;
        `CHK("started", 1'b1, converting)
        xfer(1'b1, `ACRS_OFF_SEL, sel_word(6'h1b, 3'h6));
        xfer(1'b0, `ACRS_OFF_SEL, 32'h0);
        `CHK("buffer", sel_word(6'h1b, 3'h6), rd)
        #1;
        `CHK("frozen", 6'h05, active_channel)
        wait_idle();
        `CHK("reloaded", 6'h1b, active_channel)
        @(posedge hclk);
        #1;
        `CHK("conv_len", int'(CONV) - 1, last_len)
        `CHK("irq_set", 1'b1, irq)
        xfer(1'b0, `ACRS_OFF_STATUS, 32'h0);
        `CHK("status", 32'h3, rd)
        xfer(1'b1, `ACRS_OFF_MASK, 32'h0);
        @(posedge hclk);
        #1;
        `CHK("irq_masked", 1'b0, irq)
        xfer(1'b1, `ACRS_OFF_STATUS, 32'h3);
        xfer(1'b1, `ACRS_OFF_MASK, 32'h3);
        @(posedge hclk);
        #1;
        `CHK("irq_clear", 1'b0, irq)
        xfer(1'b1, `ACRS_OFF_CTRL, 32'h1);
        repeat (4) @(posedge hclk);
        #1;
        `CHK("no_enable", 1'b0, converting)
        xfer(1'b0, 32'h40, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        xfer(1'b1, `ACRS_OFF_SEL, sel_word(6'h0e, 3'h1));
        xfer(1'b1, `ACRS_OFF_CTRL, 32'h6);
        xfer(1'b0, `ACRS_OFF_CTRL, 32'h0);
        `CHK("ctrl_reg", 32'h6, rd)
        trigger_in <= 1'b1;
        for (k = 0; k < 10 && converting !== 1'b1; k++) begin
            @(posedge hclk);
            #1;
        end
        `CHK("trig_conv", 1'b1, converting)
        xfer(1'b1, `ACRS_OFF_SEL, sel_word(6'h02, 3'h0));
        #1;
        `CHK("trig_sel", 6'h0e, active_channel)
        wait_idle();
        `CHK("trig_reload", 6'h02, active_channel)
        trigger_in <= 1'b0;
        xfer(1'b1, `ACRS_OFF_CTRL, 32'h0);
        give_verdict();
    end
endmodule
